// ==== sim/i2c_status_flags_bench.sv ====
// Self-checking bench of the status-flag block: reads, traffic, clears.
// Assumes the bus model and checker files are compiled alongside.
`timescale 1ns/1ns

module i2c_status_flags_bench;
  reg         clock;
  reg         sys_rst;
  reg  [7:0]  ctl;
  reg         start_gen;
  reg         latch;
  reg  [15:0] addr;
  reg         rd;
  reg         bitop;
  reg         clk_en;
  reg         wait_rel;
  wire        scl_low;
  wire        sda_low;
  wire        sda_oe;
  wire        sda_drv;
  wire        cpu_wait;
  wire        cpu_rd_ack;
  wire [7:0]  cpu_rdata;
  wire [7:0]  status;
  integer     n_errors;
  integer     n_checks;
  integer     cyc = 0;
  integer     i;
  integer     n;

  // Open-drain lines with pull-ups
  i2csf_top i2csf_top_inst (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .scl_in(~scl_low), .sda_in(~(sda_low | (sda_oe & ~sda_drv))),
    .sda_out(sda_drv), .sda_oe(sda_oe), .i2c_control_register(ctl),
    .start_request_bit(1'b1),
    .own_slave_address_register(8'ha4), .start_generated(start_gen),
    .wait_release(wait_rel), .serial_output_latch(latch), .cpu_addr(addr),
    .cpu_rd(rd), .cpu_bitop(bitop), .cpu_wait(cpu_wait),
    .cpu_rd_ack(cpu_rd_ack), .cpu_rdata(cpu_rdata), .i2c_bus_status(status)
  );
  i2csf_bus_model m (.scl_low(scl_low), .sda_low(sda_low));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang limit
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task tick;
    begin
      @(posedge clock);
      #1;
    end
  endtask
  task ticks(input integer k);
    repeat (k) tick;
  endtask
  task check(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Read only while the clock runs
  task read_status(input [7:0] exp);
    begin
      addr = 16'hffaa;
      rd = 1'b1;
      tick;
      n = 1;
      while (cpu_rd_ack !== 1'b1 && n < 8) begin
        tick;
        n = n + 1;
      end
      check(n[7:0], 8'h03);
      check(cpu_rdata, exp);
      tick;
      rd = 1'b0;
    end
  endtask
  task close_out;
    begin
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    n_errors = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    ctl = 8'h80;
    start_gen = 1'b0;
    latch = 1'b1;
    addr = 16'h0000;
    rd = 1'b0;
    bitop = 1'b0;
    clk_en = 1'b1;
    wait_rel = 1'b0;
    ticks(16);
    sys_rst = 1'b0;
    tick;
    check(status, 8'h00);
    read_status(8'h00);
    tick;
    addr = 16'hff00;
    rd = 1'b1;
    tick;
    rd = 1'b0;
    check({7'h00, cpu_wait}, 8'h00);
    $display("test reset done");
    m.start_cond;
    m.send_byte(8'ha5);
    ticks(4);
    check(status, 8'h1a);
    latch = 1'b0;
    tick;
    check({7'h00, sda_oe}, 8'h01);
    check({7'h00, sda_drv}, 8'h00);
    latch = 1'b1;
    tick;
    m.stop_cond;
    ticks(4);
    check(status, 8'h01);
    $display("test address match done");
    for (i = 0; i < 2; i = i + 1) begin
      m.start_cond;
      m.send_byte(i ? 8'h01 : 8'hf0);
      ticks(4);
      check(status, i ? 8'h2a : 8'h22);
      ctl = 8'hc0;
      tick;
      ctl = 8'h80;
      ticks(2);
      check(status, 8'h00);
      m.stop_cond;
      ticks(4);
      check(status, 8'h01);
    end
    $display("test extension code done");
    for (i = 0; i < 3; i = i + 1) begin
      start_gen = 1'b1;
      tick;
      start_gen = 1'b0;
      ticks(2);
      check(status, 8'h89);
      m.arb_bit;
      ticks(4);
      check(status, 8'h41);
      if (i == 0)
        read_status(8'h41);
      addr = 16'hff00;
      bitop = (i == 1);
      ctl = (i == 2) ? 8'h00 : 8'h80;
      tick;
      bitop = 1'b0;
      ctl = 8'h80;
      ticks(2);
      check(status, (i == 2) ? 8'h00 : 8'h01);
      m.stop_cond;
      ticks(4);
    end
    $display("test arbitration done");
    // Flags set, then cleared by a reset in mid-run
    start_gen = 1'b1;
    tick;
    start_gen = 1'b0;
    tick;
    check(status, 8'h89);
    wait_rel = 1'b1;
    tick;
    wait_rel = 1'b0;
    tick;
    check(status, 8'h81);
    sys_rst = 1'b1;
    tick;
    sys_rst = 1'b0;
    tick;
    check(status, 8'h00);
    check(cpu_rdata, 8'h00);
    // Low clock enable freezes an own start
    clk_en = 1'b0;
    start_gen = 1'b1;
    tick;
    start_gen = 1'b0;
    clk_en = 1'b1;
    tick;
    check(status, 8'h00);
    $display("test reset and freeze done");
    close_out;
  end
endmodule

// ==== sim/i2csf_bus_model.sv ====
// Behavioural bus master at the far side: start, bytes, stop, lost bit.
// Assumes open-drain lines with pull-ups resolved in the bench.
`timescale 1ns/1ns

module i2csf_bus_model (
  output reg scl_low,
  output reg sda_low
);
  // Lines released at start
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // Data changes mid low phase; link clock period 320 ns
  task bit_out(input b);
    begin
      scl_low = 1'b1;
      #80;
      sda_low = ~b;
      #80;
      scl_low = 1'b0;
      #160;
    end
  endtask

  // Data falls while clock high
  task start_cond;
    begin
      sda_low = 1'b1;
      #160;
    end
  endtask

  // Eight bits MSB first, ninth released, ends after ninth fall
  task send_byte(input [7:0] d);
    integer j;
    begin
      for (j = 7; j >= 0; j = j - 1) begin
        bit_out(d[j]);
      end
      bit_out(1'b1);
      scl_low = 1'b1;
      #160;
    end
  endtask

  // Zero on the line while the device sends one
  task arb_bit;
    bit_out(1'b0);
  endtask

  // Data rises while clock high, then idle
  task stop_cond;
    begin
      scl_low = 1'b1;
      #80;
      sda_low = 1'b1;
      #80;
      scl_low = 1'b0;
      #160;
      sda_low = 1'b0;
      #160;
    end
  endtask
endmodule

// ==== sim/i2csf_top_assertions.sv ====
// Concurrent checks on the ports of the status-flag block.
// Assumes one clock domain; clk_en drops only while the bus is quiet.
`timescale 1ns/1ns

module i2csf_checker (
  input wire        clock,
  input wire        sys_rst,
  input wire        clk_en,
  input wire        sda_oe,
  input wire [7:0]  i2c_control_register,
  input wire        start_generated,
  input wire [15:0] cpu_addr,
  input wire        cpu_rd,
  input wire        cpu_bitop,
  input wire        cpu_wait,
  input wire        cpu_rd_ack,
  input wire [7:0]  i2c_bus_status
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // Status read handshake steps
  sequence rd_take;
    clk_en && cpu_rd && cpu_addr == 16'hffaa && !cpu_wait && !cpu_rd_ack;
  endsequence
  sequence rd_answer;
    cpu_wait [*2] ##1 (cpu_rd_ack && !cpu_wait);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // Flag relations
  reset_clear_a: assert property (
    disable iff (1'b0) sys_rst |=> i2c_bus_status == 8'h00)
    else $error("status not cleared by reset");
  read_wait_a: assert property (rd_take |=> rd_answer)
    else $error("status read wait out of step");
  read_clear_a: assert property (
    cpu_rd_ack |=> !i2c_bus_status[6])
    else $error("arbitration flag kept after read");
  bitop_clear_a: assert property (
    clk_en && cpu_bitop && cpu_addr != 16'hffaa |=> !i2c_bus_status[6])
    else $error("arbitration flag kept after bit op");
  arb_loss_a: assert property (
    $rose(i2c_bus_status[6])
    |-> !i2c_bus_status[7] && $past(i2c_bus_status[7]))
    else $error("arbitration loss without master clear");
  master_set_a: assert property (
    clk_en && start_generated |=> i2c_bus_status[7])
    else $error("master flag not set by own start");
  exit_clear_a: assert property (
    clk_en && i2c_control_register[6]
    |=> !i2c_bus_status[7] && i2c_bus_status[5:3] == 3'h0)
    else $error("flags kept while exit held");
  enable_fall_a: assert property (
    $fell(i2c_control_register[7]) |-> ##[0:2] i2c_bus_status[7:3] == 5'h00)
    else $error("flags kept after enable fall");
  stop_clear_a: assert property (
    $rose(i2c_bus_status[0]) |-> (i2c_bus_status & 8'hbe) == 8'h00)
    else $error("flags kept at stop");
  dir_release_a: assert property (
    !i2c_bus_status[3] |-> !sda_oe)
    else $error("data driven while receiving");
endmodule

bind i2csf_top i2csf_checker i2csf_checker_inst (
  .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .sda_oe(sda_oe),
  .i2c_control_register(i2c_control_register),
  .start_generated(start_generated), .cpu_addr(cpu_addr),
  .cpu_rd(cpu_rd), .cpu_bitop(cpu_bitop), .cpu_wait(cpu_wait),
  .cpu_rd_ack(cpu_rd_ack), .i2c_bus_status(i2c_bus_status)
);

// ==== src/i2csf_cond.v ====
// Bus condition finder: clock edges, start and stop from synchronised pins.
// Assumes scl_s and sda_s are already synchronised to clock.
`timescale 1ns/1ns
`include "i2csf_defs.vh"

module i2csf_cond (
  input  wire clock,
  input  wire sys_rst,
  input  wire clk_en,
  input  wire scl_s,
  input  wire sda_s,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_det,
  output wire stop_det
);

  reg scl_q;
  reg sda_q;

  ////////////////////////////////////////////////////////////////////////////
  // Previous levels for edge finding
  always @(posedge clock) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Data moving while the clock is high marks start or stop
  assign scl_rise  = clk_en & scl_s & ~scl_q;
  assign scl_fall  = clk_en & ~scl_s & scl_q;
  assign start_det = clk_en & scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = clk_en & scl_s & scl_q & ~sda_q & sda_s;

endmodule

// ==== src/i2csf_defs.vh ====
// Constants of the I2C status-flag block: address, bit positions, resets.
// Assumes inclusion by every design file of the block, by bare name.
`ifndef I2CSF_DEFS_VH
`define I2CSF_DEFS_VH

////////////////////////////////////////////////////////////////////////////
// Register address and reset value
`define I2CSF_STATUS_ADDR   16'hffaa
`define I2CSF_STATUS_RESET  8'h00

////////////////////////////////////////////////////////////////////////////
// Status register bit positions
`define I2CSF_MSTS_BIT  7
`define I2CSF_ALD_BIT   6
`define I2CSF_EXC_BIT   5
`define I2CSF_COI_BIT   4
`define I2CSF_TRC_BIT   3
`define I2CSF_ACKD_BIT  2
`define I2CSF_STD_BIT   1
`define I2CSF_SPD_BIT   0

////////////////////////////////////////////////////////////////////////////
// Control register bit positions
`define I2CSF_CTL_EXIT_BIT    6
`define I2CSF_CTL_ENABLE_BIT  7

////////////////////////////////////////////////////////////////////////////
// Bus sequence and timing counts
`define I2CSF_ADDR_BIT_CNT  4'h8
`define I2CSF_ACK_BIT_CNT   4'h9
`define I2CSF_EXT_CODE_LO   4'h0
`define I2CSF_EXT_CODE_HI   4'hf
`define I2CSF_RD_WAIT_CYC   2'h1
`define I2CSF_SYNC_STAGES   2

`endif

// ==== src/i2csf_sync.v ====
// Two-stage synchroniser for a group of pins from outside the clock domain.
// Assumes the pins are asynchronous levels; the first stage is read only by
// the second.
`timescale 1ns/1ns
`include "i2csf_defs.vh"

module i2csf_sync #(
  parameter WIDTH = 2
) (
  input  wire             clock,
  input  wire             sys_rst,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar g;

  ////////////////////////////////////////////////////////////////////////////
  // One synchroniser pair per bit, reset to released bus level
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_q;
      reg stab_q;
      always @(posedge clock) begin
        if (sys_rst) begin
          meta_q <= 1'b1;
          stab_q <= 1'b1;
        end else if (clk_en) begin
          meta_q <= async_in[g];
          stab_q <= meta_q;
        end
      end
      assign sync_out[g] = stab_q;
    end
  endgenerate

endmodule

// ==== src/i2csf_top.v ====
// I2C status-flag logic: eight bus flags gathered into one read-only status
// register, read by the CPU with two inserted wait cycles.
// Assumes the bus-driving and shift logic sit beside this block and report
// own start generation, wait release and serial output latch on clock.
//
// Functional notes
// - Reset clears every status bit to zero.
// - Each CPU status read inserts two wait cycles before data returns.
// - Bits high to low: master, arb, ext, match, dir, ack, start, stop.
// - Master-active sets when the device generates a start.
// - Master-active clears on stop, arb loss, exit, or enable falling.
// - Arbitration loss sets arb-lost and clears master-active together.
// - Arb-lost clears after status read, enable falling, and reset.
// - Arb-lost clears on a bit instruction aimed at another address.
// - Ext-code sets at eighth clock rise when address nibble is 0000/1111.
// - Ext-code clears on start, stop, exit, or enable falling.
// - Exit bit sits at control bit 6, enable bit at bit 7.
// - Match sets at eighth clock rise on own address; clears like ext-code.
// - Direction zero releases data; one drives latch from own start, or as slave from ninth clock fall.
`timescale 1ns/1ns
`include "i2csf_defs.vh"

module i2csf_top (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  input  wire [7:0]  i2c_control_register,
  input  wire        start_request_bit,
  input  wire [7:0]  own_slave_address_register,
  input  wire        start_generated,
  input  wire        wait_release,
  input  wire        serial_output_latch,
  input  wire [15:0] cpu_addr,
  input  wire        cpu_rd,
  input  wire        cpu_bitop,
  output wire        cpu_wait,
  output wire        cpu_rd_ack,
  output reg  [7:0]  cpu_rdata,
  output wire [7:0]  i2c_bus_status
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DONE = 3'b100;

  wire [1:0] pins_s;
  wire       scl_s;
  wire       sda_s;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire       exit_communications_bit;
  wire       operation_enable_bit;
  wire       enable_fall;
  wire       clr_common;
  wire       addr_done;
  wire       ack_slot;
  wire [7:0] addr_byte;
  wire       arb_loss;
  wire       rd_hit;
  wire       rd_done;
  wire       bitop_other;

  reg        master_active_flag;
  reg        arbitration_lost_flag;
  reg        extension_code_flag;
  reg        address_match_flag;
  reg        transmit_direction_flag;
  reg        acknowledge_seen_flag;
  reg        start_seen_flag;
  reg        stop_seen_flag;
  reg        enable_q;
  reg [3:0]  bit_cnt_q;
  reg        first_byte_q;
  reg [6:0]  shift_q;
  reg        drive_en_q;
  reg [2:0]  rd_state_q;
  reg [2:0]  rd_state_d;
  reg [1:0]  wait_cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and bus condition finding
  i2csf_sync #(
    .WIDTH    (2)
  ) u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  i2csf_cond u_cond (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control bits and operation-stop edge
  // control bit places
  assign exit_communications_bit =
    i2c_control_register[`I2CSF_CTL_EXIT_BIT];
  assign operation_enable_bit =
    i2c_control_register[`I2CSF_CTL_ENABLE_BIT];

  // Enable seen last cycle, for the falling edge
  always @(posedge clock) begin
    if (sys_rst) begin
      enable_q <= 1'b0;
    end else if (clk_en) begin
      enable_q <= operation_enable_bit;
    end
  end

  assign enable_fall = clk_en & enable_q & ~operation_enable_bit;
  assign clr_common  = (clk_en & exit_communications_bit) | enable_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Bit counter and first-byte address capture
  always @(posedge clock) begin
    if (sys_rst) begin
      bit_cnt_q    <= 4'h0;
      first_byte_q <= 1'b0;
      shift_q      <= 7'h00;
    end else if (clk_en) begin
      if (start_det) begin
        bit_cnt_q    <= 4'h0;
        first_byte_q <= 1'b1;
      end else if (stop_det) begin
        bit_cnt_q    <= 4'h0;
        first_byte_q <= 1'b0;
      end else if (scl_rise) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q   <= {shift_q[5:0], sda_s};
      end else if (scl_fall && bit_cnt_q == `I2CSF_ACK_BIT_CNT) begin
        bit_cnt_q    <= 4'h0;
        first_byte_q <= 1'b0;
      end
    end
  end

  // Eighth rise completes the address byte; ninth is the acknowledge slot
  assign addr_byte = {shift_q, sda_s};
  assign addr_done = scl_rise & first_byte_q &
                     (bit_cnt_q == `I2CSF_ADDR_BIT_CNT - 4'h1);
  assign ack_slot  = scl_rise & (bit_cnt_q == `I2CSF_ACK_BIT_CNT - 4'h1);

  // Own released high level pulled low by another master
  assign arb_loss = scl_rise & master_active_flag & drive_en_q &
                    serial_output_latch & ~sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Master-active and arbitration-lost flags
  // flags clear on reset
  always @(posedge clock) begin
    if (sys_rst) begin
      master_active_flag    <= 1'b0;
      arbitration_lost_flag <= 1'b0;
    end else if (clk_en) begin
      if (arb_loss) begin
        arbitration_lost_flag <= 1'b1;
      end else if (rd_done || enable_fall) begin
        arbitration_lost_flag <= 1'b0;
      end else if (bitop_other) begin
        arbitration_lost_flag <= 1'b0;
      end
      if (start_generated) begin
        master_active_flag <= 1'b1;
      end else if (stop_det || arb_loss || clr_common) begin
        master_active_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extension-code and address-match flags
  always @(posedge clock) begin
    if (sys_rst) begin
      extension_code_flag <= 1'b0;
      address_match_flag  <= 1'b0;
    end else if (clk_en) begin
      if (addr_done && (addr_byte[7:4] == `I2CSF_EXT_CODE_LO ||
                        addr_byte[7:4] == `I2CSF_EXT_CODE_HI)) begin
        extension_code_flag <= 1'b1;
      end else if (start_det || stop_det || clr_common) begin
        extension_code_flag <= 1'b0;
      end
      if (addr_done &&
          addr_byte[7:1] == own_slave_address_register[7:1]) begin
        address_match_flag <= 1'b1;
      end else if (start_det || stop_det || clr_common) begin
        address_match_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction flag and data-line drive window
  always @(posedge clock) begin
    if (sys_rst) begin
      transmit_direction_flag <= 1'b0;
      drive_en_q              <= 1'b0;
    end else if (clk_en) begin
      if (start_generated) begin
        transmit_direction_flag <= 1'b1;
      end else if (addr_done && master_active_flag) begin
        transmit_direction_flag <= ~sda_s;
      end else if (addr_done && !master_active_flag) begin
        transmit_direction_flag <= sda_s;
      end else if (stop_det || clr_common || wait_release || arb_loss ||
                   (start_det && !master_active_flag)) begin
        transmit_direction_flag <= 1'b0;
      end
      if (start_generated) begin
        drive_en_q <= 1'b1;
      end else if (!transmit_direction_flag) begin
        drive_en_q <= 1'b0;
      end else if (scl_fall && first_byte_q &&
                   bit_cnt_q == `I2CSF_ACK_BIT_CNT) begin
        drive_en_q <= 1'b1;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = transmit_direction_flag & drive_en_q &
                   ~serial_output_latch;

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge, start and stop flags
  always @(posedge clock) begin
    if (sys_rst) begin
      acknowledge_seen_flag <= 1'b0;
      start_seen_flag       <= 1'b0;
      stop_seen_flag        <= 1'b0;
    end else if (clk_en) begin
      if (ack_slot) begin
        acknowledge_seen_flag <= ~sda_s;
      end else if (start_det || stop_det || clr_common) begin
        acknowledge_seen_flag <= 1'b0;
      end
      if (start_det) begin
        start_seen_flag <= 1'b1;
      end else if (stop_det || clr_common) begin
        start_seen_flag <= 1'b0;
      end
      if (stop_det) begin
        stop_seen_flag <= 1'b1;
      end else if (start_det || enable_fall) begin
        stop_seen_flag <= 1'b0;
      end
    end
  end

  assign i2c_bus_status = {master_active_flag, arbitration_lost_flag,
                           extension_code_flag, address_match_flag,
                           transmit_direction_flag, acknowledge_seen_flag,
                           start_seen_flag, stop_seen_flag};

  ////////////////////////////////////////////////////////////////////////////
  // CPU read sequencer with inserted wait
  assign rd_hit      = cpu_rd & (cpu_addr == `I2CSF_STATUS_ADDR);
  assign bitop_other = cpu_bitop & (cpu_addr != `I2CSF_STATUS_ADDR);
  assign rd_done     = rd_state_q[2];
  assign cpu_wait    = rd_state_q[1];
  assign cpu_rd_ack  = rd_state_q[2];

  always @* begin
    rd_state_d = rd_state_q;
    case (rd_state_q)
      ST_IDLE: begin
        if (rd_hit) begin
          rd_state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_cnt_q == `I2CSF_RD_WAIT_CYC) begin
          rd_state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        rd_state_d = ST_IDLE;
      end
      default: begin
        rd_state_d = ST_IDLE;
      end
    endcase
  end

  // State, wait count and returned data
  always @(posedge clock) begin
    if (sys_rst) begin
      rd_state_q <= ST_IDLE;
      wait_cnt_q <= 2'h0;
      cpu_rdata  <= `I2CSF_STATUS_RESET;
    end else if (clk_en) begin
      rd_state_q <= rd_state_d;
      if (rd_state_q == ST_WAIT) begin
        wait_cnt_q <= wait_cnt_q + 2'h1;
      end else begin
        wait_cnt_q <= 2'h0;
      end
      if (rd_state_q == ST_WAIT &&
          wait_cnt_q == `I2CSF_RD_WAIT_CYC) begin
        cpu_rdata <= i2c_bus_status;
      end
    end
  end

endmodule
